// file: pkg/rtgc_regs.svh
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: included by bare name from the design files
// Notes:   offsets are the printed serial register addresses
`ifndef RTGC_REGS_SVH
`define RTGC_REGS_SVH

`define RTGC_ADDR_RX_GAIN     8'h09
`define RTGC_ADDR_TX_ATTEN    8'h0A
`define RTGC_ADDR_SRC_CFG     8'h0B
`define RTGC_ADDR_TX_OUT_CFG  8'h0E

`define RTGC_BIT_UPD_EN       6
`define RTGC_BIT_TXSEL        6
`define RTGC_BIT_RXSEL        5
`define RTGC_BIT_SW_STROBE    3
`define RTGC_BIT_NIB_EN       2
`define RTGC_BIT_MAP3         1
`define RTGC_BIT_CONV_ONLY    0

`define RTGC_RX_GAIN_RST      6'h00
`define RTGC_TX_ATTEN_RST     6'h00
`define RTGC_RX_MIN_DB        8'hF4
`define RTGC_MAP3_STEP_DB     8'h08

`define RTGC_SER_CLK_MHZ      32
`define RTGC_CORE_CLK_MHZ     50
`define RTGC_SER_BITS         20
`define RTGC_IFACE_DIV        4'h4

`endif

// file: pkg/rtgc_pkg.sv
// Purpose: shared types of the gain-control block
// Assumes: constants live in rtgc_regs.svh
// Notes:   types only
package rtgc_pkg;
    typedef logic [5:0] rtgc_code_t;
    typedef struct packed
    {
        logic [2:0] stage1;
        logic [2:0] stage2;
        logic [2:0] stage3;
    } rtgc_stages_t;
    typedef enum logic [2:0]
    {
        RTGC_IDLE  = 3'b001,
        RTGC_SHIFT = 3'b010,
        RTGC_DONE  = 3'b100
    } rtgc_ser_state_t;
endpackage

// file: pkg/rtgc_if.sv
// Purpose: pins between the front-end gain logic and the baseband asic
// Assumes: both ends on i_core_clk
// Notes:   serial data return is a plain one-way pin
`timescale 1ns/1ns
interface rtgc_if;
    logic       iface_clock_out; // interface clock enable from device
    logic [5:0] tx_nibble;       // transmit nibble port
    logic       tx_nibble_sync;  // nibble sync
    logic       gain_strobe;     // gain strobe pin
    logic [5:0] direct_gain_port;// direct gain port
    logic       ser_sel;         // serial select, high during a frame
    logic       ser_clk;         // serial bit enable
    logic       ser_din;         // serial data to device
    logic       ser_dout;        // serial data from device

    modport dev
    (
        output iface_clock_out,
        input  tx_nibble, tx_nibble_sync, gain_strobe, direct_gain_port,
        input  ser_sel, ser_clk, ser_din,
        output ser_dout
    );
    modport asic
    (
        input  iface_clock_out,
        output tx_nibble, tx_nibble_sync, gain_strobe, direct_gain_port,
        output ser_sel, ser_clk, ser_din,
        input  ser_dout
    );
endinterface

// file: verilog/rtgc_asic_end.sv
// Purpose: baseband side driving the gain ports and the serial port
// Assumes: user requests one at a time while o_busy is low
// Notes:   serial frame = rw, 7-bit addr, 8-bit data, msb first
`timescale 1ns/1ns
`include "rtgc_regs.svh"
module rtgc_asic_end
(
    input  wire logic       i_core_clk,  // 50 MHz clock
    input  wire logic       i_reset,     // sync reset, high
    rtgc_if.asic            bus,         // pins to device
    input  wire logic       i_ser_req,   // start serial access
    input  wire logic       i_ser_wr,    // 1 write, 0 read
    input  wire logic [6:0] i_ser_addr,  // register address
    input  wire logic [7:0] i_ser_wdata, // write data
    input  wire logic       i_gain_req,  // load gain via nibble port
    input  wire logic [5:0] i_gain_code, // gain code for nibble port
    input  wire logic [5:0] i_direct,    // value for direct port
    input  wire logic [5:0] i_tx_data,   // transmit nibble data
    input  wire logic       i_tx_sync,   // transmit nibble sync
    output logic      [7:0] o_ser_rdata, // read data
    output logic            o_ser_done,  // access finished pulse
    output logic            o_busy       // transfer in progress
);
    // ------------------------------------------------------------
    // serial master
    // ------------------------------------------------------------
    logic [15:0] sh;
    logic [4:0]  cnt;
    logic        rd;
    logic        phase;
    logic        gain_act;
    logic        gain_seen;

    // bit clock enable: one bit every other cycle
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            phase <= 1'b0;
        else
            phase <= ~phase;
    end

    // shift frame out, sample return on the same enable
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sh <= 16'h0000;
            cnt <= 5'h00;
            rd <= 1'b0;
            bus.ser_sel <= 1'b0;
            bus.ser_clk <= 1'b0;
            bus.ser_din <= 1'b0;
            o_ser_rdata <= 8'h00;
            o_ser_done <= 1'b0;
        end
        else
        begin
            o_ser_done <= 1'b0;
            bus.ser_clk <= 1'b0;
            if (!bus.ser_sel && i_ser_req)
            begin
                sh <= {~i_ser_wr, i_ser_addr, i_ser_wdata};
                rd <= ~i_ser_wr;
                cnt <= 5'h10;
                bus.ser_sel <= 1'b1;
            end
            else if (bus.ser_sel && phase)
            begin
                if (cnt == 5'h00)
                begin
                    bus.ser_sel <= 1'b0;
                    o_ser_done <= 1'b1;
                    // last read bit comes back one enable after the last pulse
                    if (rd)
                        o_ser_rdata <= {sh[6:0], bus.ser_dout};
                end
                else
                begin
                    bus.ser_din <= sh[15];
                    bus.ser_clk <= 1'b1;
                    sh <= {sh[14:0], bus.ser_dout};
                    cnt <= cnt - 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // nibble and gain ports
    // ------------------------------------------------------------
    // gain strobe held across two interface clock pulses, sync low;
    // the second pulse covers the two-flop delay on the device pins
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            gain_seen <= 1'b0;
            gain_act <= 1'b0;
            bus.gain_strobe <= 1'b0;
            bus.tx_nibble <= 6'h00;
            bus.tx_nibble_sync <= 1'b0;
            bus.direct_gain_port <= 6'h00;
        end
        else
        begin
            bus.direct_gain_port <= i_direct;
            if (!gain_act && i_gain_req)
            begin
                gain_act <= 1'b1;
                gain_seen <= 1'b0;
                bus.gain_strobe <= 1'b1;    // RULE_08
                bus.tx_nibble_sync <= 1'b0; // RULE_08
                bus.tx_nibble <= i_gain_code;
            end
            else if (gain_act)
            begin
                if (bus.iface_clock_out)
                    gain_seen <= 1'b1;
                if (bus.iface_clock_out && gain_seen)
                begin
                    gain_act <= 1'b0;
                    bus.gain_strobe <= 1'b0; // RULE_08
                end
            end
            else
            begin
                bus.gain_strobe <= 1'b0; // RULE_23
                bus.tx_nibble <= i_tx_data;
                bus.tx_nibble_sync <= i_tx_sync;
            end
        end
    end

    // busy flag
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_busy <= 1'b0;
        else
            o_busy <= bus.ser_sel | gain_act | i_ser_req | i_gain_req;
    end
endmodule

// file: verilog/rtgc_dev_end.sv
// Function
// RULE_01: six-bit receive gain, -12 to +48 dB; code maps 0..63 to -12..+51 dB
// RULE_02: lookup spreads gain over three stages
// RULE_03: receive gain resets to -12 dB
// RULE_04: three load sources for receive gain
// RULE_05: serial write/readback of receive code
// RULE_06: software sets update bit per access
// RULE_07: nibble-port loading only in full duplex
// RULE_08: strobe high, sync low, one clock
// RULE_09: strobe low routes nibbles to filter
// RULE_10: software strobe acts as held strobe
// RULE_11: config bit enables nibble-port gain loading
// RULE_12: direct port loads selected register unstrobed
// RULE_13: direct port default in half duplex
// RULE_14: bits select receive or transmit routing
// RULE_15: software sequences direct port switch-over
// RULE_16: 3-bit map from port bits 5:3
// RULE_17: config bit selects 3-bit mapping
// RULE_18: six-bit transmit attenuation word
// RULE_19: converter-only map uses four lsbs
// RULE_20: serial access of transmit attenuation code
// RULE_21: transmit attenuation resets to minimum
// RULE_22: config bit bypasses current amplifier
// RULE_23: strobe low during transmit data
// RULE_24: readback returns current register contents
//
// Purpose: gain registers of the front end, device side
// Assumes: mode and config straps are static; pins cross two flops
// Notes:   serial frame = rw(1 read), 7-bit addr, 8-bit data, msb first
`timescale 1ns/1ns
`include "rtgc_regs.svh"
module rtgc_dev_end
#(
    parameter logic [3:0] IFACE_DIV = `RTGC_IFACE_DIV // clock enable divider
)
(
    input  wire logic        i_core_clk,    // 50 MHz clock
    input  wire logic        i_reset,       // sync reset, high
    rtgc_if.dev              bus,           // pins to asic
    input  wire logic        i_mode_full,   // mode strap, 1 full duplex
    input  wire logic        i_config_hi,   // config strap
    output logic       [5:0] o_rx_gain,     // receive gain code
    output rtgc_pkg::rtgc_stages_t o_stages,// three stage settings
    output logic       [7:0] o_rx_gain_db,  // applied gain, signed dB
    output logic       [5:0] o_tx_atten,    // transmit attenuation word
    output logic       [3:0] o_conv_atten,  // converter attenuation
    output logic       [5:0] o_amp_atten,   // current amplifier attenuation
    output logic             o_amp_enable,  // current amplifier path on
    output logic       [5:0] o_filt_data,   // nibble to interpolation filter
    output logic             o_filt_valid,  // nibble valid
    output logic             o_filt_sync    // nibble sync to filter
);
    // ------------------------------------------------------------
    // pin synchronisers and interface clock
    // ------------------------------------------------------------
    logic [17:0] s1;
    logic [17:0] s2;
    logic [3:0]  div;
    logic        ick;
    logic        sclk_q;
    logic [7:0]  src_cfg;
    logic [7:0]  out_cfg;
    logic [5:0]  rx_gain;
    logic [5:0]  tx_atten;
    logic        strap_done;

    // two flops for every asynchronous pin
    always_ff @(posedge i_core_clk)
    begin
        s1 <= {i_mode_full, i_config_hi, bus.tx_nibble, bus.tx_nibble_sync, bus.gain_strobe,
               bus.direct_gain_port, bus.ser_sel, bus.ser_clk};
        s2 <= s1;
    end

    wire [5:0] p_nib  = s2[15:10];
    wire       p_sync = s2[9];
    wire       p_gain = s2[8];
    wire [5:0] p_dir  = s2[7:2];
    wire       p_sel  = s2[1];
    wire       p_sclk = s2[0];
    wire       p_mode = s2[17]; // straps are pins as well
    wire       p_cfg  = s2[16];

    // divider gives the interface clock enable, driven out as well
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            div <= 4'h0;
            ick <= 1'b0;
        end
        else
        begin
            div <= (div == IFACE_DIV - 4'h1) ? 4'h0 : div + 4'h1;
            ick <= (div == IFACE_DIV - 4'h1);
        end
    end

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    logic [15:0] sh;
    logic [4:0]  bits;
    logic        ser_din_q;
    logic [7:0]  rsh;
    logic        wr_stb;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        s1d;

    // data pin synchronised apart, sampled on the bit enable
    always_ff @(posedge i_core_clk)
    begin
        s1d <= bus.ser_din;
        ser_din_q <= s1d;
    end

    // read returns the live register at address phase end
    function automatic logic [7:0] rd_val(input logic [6:0] a);
        case ({1'b0, a})
            `RTGC_ADDR_RX_GAIN:    rd_val = {2'b01, rx_gain};  // RULE_24
            `RTGC_ADDR_TX_ATTEN:   rd_val = {2'b01, tx_atten}; // RULE_24
            `RTGC_ADDR_SRC_CFG:    rd_val = src_cfg;
            `RTGC_ADDR_TX_OUT_CFG: rd_val = out_cfg;
            default:               rd_val = 8'h00;
        endcase
    endfunction

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sh <= 16'h0000;
            bits <= 5'h00;
            sclk_q <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
            rsh <= 8'h00;
        end
        else
        begin
            sclk_q <= p_sclk;
            wr_stb <= 1'b0;
            if (!p_sel)
                bits <= 5'h00;
            else if (p_sclk && !sclk_q)
            begin
                sh <= {sh[14:0], ser_din_q};
                bits <= bits + 5'h01;
                // read data on its own shifter so the frame bits stay intact
                if (bits == 5'h07 && sh[6])
                    rsh <= rd_val({sh[5:0], ser_din_q});
                else
                    rsh <= {rsh[6:0], 1'b0};
                if (bits == 5'h0F && !sh[14])
                begin
                    wr_stb <= 1'b1;
                    wr_addr <= sh[13:7];
                    wr_data <= {sh[6:0], ser_din_q};
                end
            end
        end
    end
    assign bus.ser_dout = rsh[7]; // straight from the flop, no extra cycle
    assign bus.iface_clock_out = ick;

    // ------------------------------------------------------------
    // configuration registers, straps taken after reset
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            src_cfg <= 8'h00;
            out_cfg <= 8'h00;
            strap_done <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_done <= 1'b1;
            src_cfg[`RTGC_BIT_NIB_EN] <= p_mode;           // RULE_07
            src_cfg[`RTGC_BIT_RXSEL]  <= ~p_mode;          // RULE_13
            src_cfg[`RTGC_BIT_MAP3]   <= ~p_mode & p_cfg;  // RULE_17
        end
        else if (wr_stb && {1'b0, wr_addr} == `RTGC_ADDR_SRC_CFG)
            src_cfg <= wr_data;
        else if (wr_stb && {1'b0, wr_addr} == `RTGC_ADDR_TX_OUT_CFG)
            out_cfg <= wr_data;
    end

    // ------------------------------------------------------------
    // gain registers
    // ------------------------------------------------------------
    wire strobe  = p_gain | src_cfg[`RTGC_BIT_SW_STROBE];            // RULE_10
    wire nib_ld  = p_mode & src_cfg[`RTGC_BIT_NIB_EN]                // RULE_11
                   & strobe & ~p_sync & ick;                          // RULE_08
    wire rx_dir  = src_cfg[`RTGC_BIT_RXSEL];                          // RULE_14
    wire tx_dir  = src_cfg[`RTGC_BIT_TXSEL];                          // RULE_14
    wire rx_spi  = wr_stb && {1'b0, wr_addr} == `RTGC_ADDR_RX_GAIN
                   && wr_data[`RTGC_BIT_UPD_EN];                      // RULE_06
    wire tx_spi  = wr_stb && {1'b0, wr_addr} == `RTGC_ADDR_TX_ATTEN
                   && wr_data[`RTGC_BIT_UPD_EN];                      // RULE_20

    // receive gain: serial over nibble over direct port
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !strap_done)
            rx_gain <= `RTGC_RX_GAIN_RST; // RULE_03
        else if (rx_spi)
            rx_gain <= wr_data[5:0];      // RULE_05
        else if (nib_ld)
            rx_gain <= p_nib;             // RULE_04
        else if (rx_dir)
            rx_gain <= p_dir;             // RULE_12
    end

    // transmit attenuation: serial over direct port
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            tx_atten <= `RTGC_TX_ATTEN_RST; // RULE_21
        else if (tx_spi)
            tx_atten <= wr_data[5:0];       // RULE_20
        else if (tx_dir)
            tx_atten <= p_dir;              // RULE_12
    end

    // ------------------------------------------------------------
    // gain mapping and outputs
    // ------------------------------------------------------------
    // 3-bit map: 000/001 -> -12 dB, else +8 dB per step
    function automatic logic [7:0] gain_db(input logic [5:0] c, input logic m3);
        logic [2:0] k;
        k = c[5:3];
        if (m3)
            gain_db = (k < 3'h2) ? `RTGC_RX_MIN_DB                    // RULE_16
                      : 8'(`RTGC_RX_MIN_DB + (k - 3'h1) * `RTGC_MAP3_STEP_DB);
        else
            gain_db = 8'(`RTGC_RX_MIN_DB + {2'b00, c});               // RULE_01
    endfunction

    // lookup: total 0..63 dB above minimum split into three stages
    function automatic rtgc_pkg::rtgc_stages_t split(input logic [7:0] db);
        logic [7:0] u;
        rtgc_pkg::rtgc_stages_t s;
        u = 8'(db - `RTGC_RX_MIN_DB);
        s.stage1 = (u > 8'h17) ? 3'h7 : 3'(u >> 2);
        s.stage2 = (u > 8'h2F) ? 3'h7 : (u > 8'h17) ? 3'(8'(u - 8'h18) >> 2) : 3'h0;
        s.stage3 = (u > 8'h2F) ? 3'(8'(u - 8'h30) >> 2) : 3'h0;
        split = s;
    endfunction

    // registered outputs
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_rx_gain <= 6'h00;
            o_rx_gain_db <= `RTGC_RX_MIN_DB;
            o_stages <= '0;
            o_tx_atten <= 6'h00;
            o_conv_atten <= 4'h0;
            o_amp_atten <= 6'h00;
            o_amp_enable <= 1'b1;
        end
        else
        begin
            o_rx_gain <= rx_gain;
            o_rx_gain_db <= gain_db(rx_gain, src_cfg[`RTGC_BIT_MAP3]);
            o_stages <= split(gain_db(rx_gain, src_cfg[`RTGC_BIT_MAP3])); // RULE_02
            o_tx_atten <= tx_atten;                                        // RULE_18
            o_conv_atten <= out_cfg[`RTGC_BIT_CONV_ONLY] ? tx_atten[3:0]   // RULE_19
                            : 4'h0;
            o_amp_atten <= out_cfg[`RTGC_BIT_CONV_ONLY] ? 6'h00 : tx_atten;
            o_amp_enable <= ~out_cfg[`RTGC_BIT_CONV_ONLY];                 // RULE_22
        end
    end

    // nibbles go to the filter only while no strobe
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_filt_data <= 6'h00;
            o_filt_valid <= 1'b0;
            o_filt_sync <= 1'b0;
        end
        else
        begin
            o_filt_valid <= ick & ~strobe & p_mode; // RULE_09
            o_filt_data <= p_nib;
            o_filt_sync <= p_sync;
        end
    end
endmodule

// file: tb/rtgc_props.sv
// Purpose: pin-level timing checks between the device end and the asic end
// Assumes: default interface clock divider of four core cycles
// Notes:   sees only the interface pins, clock and reset
`timescale 1ns/1ns
module rtgc_props
(
    input  wire logic       i_core_clk,       // 50 MHz clock
    input  wire logic       i_reset,          // sync reset, high
    input  wire logic       iface_clock_out,  // interface clock enable
    input  wire logic [5:0] tx_nibble,        // transmit nibble port
    input  wire logic       tx_nibble_sync,   // nibble sync
    input  wire logic       gain_strobe,      // gain strobe pin
    input  wire logic [5:0] direct_gain_port, // direct gain port
    input  wire logic       ser_sel,          // serial select
    input  wire logic       ser_clk,          // serial bit pulse
    input  wire logic       ser_din,          // serial data in
    input  wire logic       ser_dout          // serial data out
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    logic [4:0] ser_bits; // bit pulses seen in this frame

    // ------------------------------------------------------------
    // frame bit counter
    // ------------------------------------------------------------
    // cleared whenever select drops so a cut frame cannot leak over
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || !ser_sel)
            ser_bits <= 5'h00;
        else if (ser_clk)
            ser_bits <= ser_bits + 5'h01;
    end

    property p_iface_pulse;
        iface_clock_out |=> !iface_clock_out [*3] ##1 iface_clock_out;
    endproperty
    a_iface_pulse: assert property (p_iface_pulse)
        else $error("interface clock pulse spacing wrong");

    property p_bit_in_frame;
        ser_clk |-> ser_sel;
    endproperty
    a_bit_in_frame: assert property (p_bit_in_frame)
        else $error("serial bit pulse outside a frame");

    property p_bit_single;
        ser_clk |=> !ser_clk;
    endproperty
    a_bit_single: assert property (p_bit_single)
        else $error("serial bit pulse longer than one cycle");

    property p_frame_start;
        $rose(ser_sel) |-> ##[1:8] ser_clk;
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame started without bit pulses");

    property p_frame_len;
        $fell(ser_sel) |-> ser_bits == 5'h10;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("serial frame not sixteen bits");

    property p_strobe_sync;
        gain_strobe |-> !tx_nibble_sync;
    endproperty
    a_strobe_sync: assert property (p_strobe_sync)
        else $error("nibble sync high during gain strobe");

    property p_strobe_hold;
        $rose(gain_strobe) |-> ##[0:4] (iface_clock_out && gain_strobe);
    endproperty
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("gain strobe dropped before an interface clock");

    property p_strobe_data;
        gain_strobe && $past(gain_strobe) |-> $stable(tx_nibble);
    endproperty
    a_strobe_data: assert property (p_strobe_data)
        else $error("gain data moved under the strobe");

    c_frame:  cover property ($fell(ser_sel));
    c_strobe: cover property (iface_clock_out && gain_strobe);
    c_direct: cover property ($changed(direct_gain_port));
endmodule

// file: tb/rtgc_test.sv
// Purpose: drives the asic end user side and checks the device end outputs
// Assumes: straps changed only under reset
// Notes:   fixed settle waits cover the two-flop pin synchronisers
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module rtgc_test;
    logic i_core_clk = 1'b0, i_reset = 1'b1, i_mode_full = 1'b0, i_config_hi = 1'b1;
    logic i_ser_req = 1'b0, i_ser_wr = 1'b0, i_gain_req = 1'b0, i_tx_sync = 1'b0;
    logic [6:0] i_ser_addr = 7'h00;
    logic [7:0] i_ser_wdata = 8'h00, rd, o_ser_rdata, o_rx_gain_db;
    logic [5:0] i_gain_code = 6'h00, i_direct = 6'h00, i_tx_data = 6'h00, filt_seen;
    logic [5:0] o_rx_gain, o_tx_atten, o_amp_atten, o_filt_data;
    logic [3:0] o_conv_atten;
    logic o_ser_done, o_busy, o_amp_enable, o_filt_valid, o_filt_sync;
    rtgc_pkg::rtgc_stages_t o_stages;
    int mismatches = 0, comparisons = 0;

    always #10 i_core_clk = ~i_core_clk;

    rtgc_if rtgc_if_i ();
    rtgc_dev_end rtgc_dev_end_i (.i_core_clk(i_core_clk), .i_reset(i_reset), .bus(rtgc_if_i),
        .i_mode_full(i_mode_full), .i_config_hi(i_config_hi), .o_rx_gain(o_rx_gain),
        .o_stages(o_stages), .o_rx_gain_db(o_rx_gain_db), .o_tx_atten(o_tx_atten),
        .o_conv_atten(o_conv_atten), .o_amp_atten(o_amp_atten),
        .o_amp_enable(o_amp_enable), .o_filt_data(o_filt_data),
        .o_filt_valid(o_filt_valid), .o_filt_sync(o_filt_sync));
    rtgc_asic_end rtgc_asic_end_i (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .bus(rtgc_if_i), .i_ser_req(i_ser_req), .i_ser_wr(i_ser_wr),
        .i_ser_addr(i_ser_addr), .i_ser_wdata(i_ser_wdata), .i_gain_req(i_gain_req),
        .i_gain_code(i_gain_code), .i_direct(i_direct), .i_tx_data(i_tx_data),
        .i_tx_sync(i_tx_sync), .o_ser_rdata(o_ser_rdata), .o_ser_done(o_ser_done),
        .o_busy(o_busy));
    rtgc_props rtgc_props_i (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .iface_clock_out(rtgc_if_i.iface_clock_out), .tx_nibble(rtgc_if_i.tx_nibble),
        .tx_nibble_sync(rtgc_if_i.tx_nibble_sync), .gain_strobe(rtgc_if_i.gain_strobe),
        .direct_gain_port(rtgc_if_i.direct_gain_port), .ser_sel(rtgc_if_i.ser_sel),
        .ser_clk(rtgc_if_i.ser_clk), .ser_din(rtgc_if_i.ser_din),
        .ser_dout(rtgc_if_i.ser_dout));

    // last nibble handed to the filter, since the valid flag is a pulse
    always @(posedge i_core_clk)
    begin
        if (o_filt_valid === 1'b1)
            filt_seen <= o_filt_data;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    task automatic do_reset(input logic full, input logic cfg);
        i_reset = 1'b1;
        i_mode_full = full;
        i_config_hi = cfg;
        tick(20);
        i_reset = 1'b0;
        tick(4);
    endtask

    // one serial access, bounded wait on the done pulse
    task automatic ser(input logic wr, input logic [6:0] a, input logic [7:0] d);
        int k;
        i_ser_wr = wr;
        i_ser_addr = a;
        i_ser_wdata = d;
        i_ser_req = 1'b1;
        tick(1);
        i_ser_req = 1'b0;
        for (k = 0; k < 300 && o_ser_done !== 1'b1; k++)
            tick(1);
        if (k == 300)
            `CHK("ser_done", 1'b1, o_ser_done)
        rd = o_ser_rdata;
        tick(8);
    endtask

    task automatic end_sim;
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #400000;
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        tick(1);
        do_reset(1'b0, 1'b1);
        `CHK("rx_gain_rst", 6'h00, o_rx_gain)
        `CHK("rx_db_rst", 8'hF4, o_rx_gain_db)
        `CHK("tx_atten_rst", 6'h00, o_tx_atten)
        `CHK("amp_en_rst", 1'b1, o_amp_enable)
        ser(1'b1, 7'h0B, 8'h00);
        ser(1'b0, 7'h0B, 8'h00);
        `CHK("src_cfg_rd", 8'h00, rd)
        // half duplex with config high: direct port, 3-bit map
        do_reset(1'b0, 1'b1);
        ser(1'b0, 7'h0B, 8'h00);
        `CHK("src_cfg_half", 8'h22, rd)
        for (int c = 0; c < 8; c++)
        begin
            i_direct = {c[2:0], 3'b000};
            tick(12);
            `CHK("map3_db", 8'((c < 2) ? 8'hF4 : 8'hF4 + 8'h08 * (c - 1)), o_rx_gain_db)
        end
        ser(1'b1, 7'h0B, 8'h20);
        i_direct = 6'h3C;
        tick(12);
        `CHK("rx_direct", 6'h3C, o_rx_gain)
        `CHK("rx_db_max", 8'h30, o_rx_gain_db)
        `CHK("stages_max", 9'h1FB, o_stages)
        ser(1'b1, 7'h0B, 8'h00);
        ser(1'b1, 7'h09, 8'h45);
        ser(1'b0, 7'h09, 8'h00);
        `CHK("rx_rd", 8'h45, rd)
        ser(1'b1, 7'h09, 8'h0A);
        `CHK("rx_no_upd", 6'h05, o_rx_gain)
        // move direct port from receive to transmit
        i_direct = 6'h2B;
        tick(12);
        ser(1'b1, 7'h0B, 8'h40);
        tick(12);
        `CHK("tx_direct", 6'h2B, o_tx_atten)
        `CHK("rx_kept", 6'h05, o_rx_gain)
        `CHK("amp_atten", 6'h2B, o_amp_atten)
        ser(1'b0, 7'h0A, 8'h00);
        `CHK("tx_rd", 8'h6B, rd)
        ser(1'b1, 7'h0B, 8'h00);
        ser(1'b1, 7'h0A, 8'h52);
        `CHK("tx_ser", 6'h12, o_tx_atten)
        ser(1'b1, 7'h0E, 8'h01);
        tick(4);
        `CHK("conv_atten", 4'h2, o_conv_atten)
        `CHK("amp_off", 1'b0, o_amp_enable)
        `CHK("amp_zero", 6'h00, o_amp_atten)
        ser(1'b0, 7'h3F, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        // full duplex: nibble port loads receive gain
        do_reset(1'b1, 1'b0);
        ser(1'b0, 7'h0B, 8'h00);
        `CHK("src_cfg_full", 8'h04, rd)
        i_gain_code = 6'h14;
        i_gain_req = 1'b1;
        tick(1);
        i_gain_req = 1'b0;
        tick(16);
        `CHK("rx_nibble", 6'h14, o_rx_gain)
        i_tx_data = 6'h15;
        tick(16);
        `CHK("filt_data", 6'h15, filt_seen)
        `CHK("rx_not_tx", 6'h14, o_rx_gain)
        `CHK("filt_sync", 1'b0, o_filt_sync)
        ser(1'b1, 7'h0B, 8'h0C);
        i_tx_data = 6'h11;
        tick(16);
        `CHK("rx_sw_strobe", 6'h11, o_rx_gain)
        `CHK("busy_idle", 1'b0, o_busy)
        end_sim();
    end
endmodule
